/* File: design/pcfg_pkg.sv */
// pcfg_pkg: register map, reset values and carrier types for the port block
package pcfg_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register pages
  localparam logic [7:0] PG_MAIN = 8'h00;
  localparam logic [7:0] PG_ALT  = 8'h0f;

  //////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] AD_P3_DRIVE_STRENGTH = 8'ha1;
  localparam logic [7:0] AD_P2_MODE_OR_DRIVE  = 8'ha6;
  localparam logic [7:0] AD_P3_LATCH_DATA     = 8'hb0;
  localparam logic [7:0] AD_P3_OUTPUT_MODE    = 8'hb1;
  localparam logic [7:0] AD_P2_CROSSBAR_SKIP  = 8'hd6;
  localparam logic [7:0] AD_P3_ANALOG_SELECT  = 8'hf1;
  localparam logic [7:0] AD_P2_ANALOG_SELECT  = 8'hf3;

  //////////////////////////////////////////////////////////////////////////
  // reset values and field positions
  localparam logic [7:0] RV_P3_DRIVE_STRENGTH = 8'h00;
  localparam logic [7:0] RV_P2_OUTPUT_MODE    = 8'h00;
  localparam logic [7:0] RV_P2_DRIVE_STRENGTH = 8'h00;
  localparam logic [7:0] RV_P3_LATCH_DATA     = 8'hff;
  localparam logic [7:0] RV_P3_OUTPUT_MODE    = 8'h00;
  localparam logic [7:0] RV_P2_CROSSBAR_SKIP  = 8'h00;
  localparam logic [7:0] RV_P3_ANALOG_SELECT  = 8'hff;
  localparam logic [6:0] RV_P2_ANALOG_SELECT  = 7'h7f;
  localparam int         P2_ANALOG_RSVD_BIT   = 7;
  localparam logic       P2_ANALOG_RSVD_VAL   = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       bit_wr;
    logic [2:0] bit_idx;
    logic       bit_val;
    logic [7:0] wdata;
  } pcfg_sfr_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       hit;
  } pcfg_sfr_rsp_t;

  typedef struct packed {
    logic [7:0] skip;
    logic [7:0] rx_en;
    logic [7:0] push_pull;
    logic [7:0] high_drive;
  } pcfg_p2_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] high_drive;
    logic [7:0] rx_en;
  } pcfg_p3_pad_t;

endpackage : pcfg_pkg

/* File: design/pcfg_port_config.sv */
// pcfg_port_config: port 2 and port 3 configuration, latches and readback
//
// Operation
// - port 2 skip bit 1 makes the crossbar pass over that pin
// - analog bit 0 turns off pin pull-up and digital receiver only
// - analog bit 1 keeps pull-up and digital receiver working
// - port 2 analog bit 7 reserved: reads 1, software writes 1
// - output-mode bit 0 open-drain, 1 push-pull
// - output-mode bits steer the driver even for analog pins
// - drive-strength bit 0 low strength, 1 high strength
// - bit n of each config register controls pin n
// - writing port 3 data loads output latches, 0 low, 1 high
// - reading port 3 data returns sensed pin levels, not latches
// - port 3 data sits at 0xb0 on every page, bit-writable
// - 0xa6 is port 2 drive strength on page 0x0f, mode on page 0
// - port 3 analog, mode, strength at 0xf1, 0xb1, 0xa1 on page 0xf
// - port 2 skip and analog at 0xd6 and 0xf3 on page 0
`timescale 1ns/1ps

module pcfg_port_config (
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_n,
  // special function register bus
  input  wire pcfg_pkg::pcfg_sfr_req_t i_sfr_req,
  output      pcfg_pkg::pcfg_sfr_rsp_t o_sfr_rsp,
  // sensed pin levels
  input  wire logic [7:0]              i_p3_pin,
  // pad controls
  output      pcfg_pkg::pcfg_p2_cfg_t  o_p2_cfg,
  output      pcfg_pkg::pcfg_p3_pad_t  o_p3_pad
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]              p2_skip;
    logic [6:0]              p2_analog;
    logic [7:0]              p2_mode;
    logic [7:0]              p2_drive;
    logic [7:0]              p3_latch;
    logic [7:0]              p3_analog;
    logic [7:0]              p3_mode;
    logic [7:0]              p3_drive;
    pcfg_pkg::pcfg_sfr_rsp_t rsp;
    pcfg_pkg::pcfg_p2_cfg_t  p2_cfg;
    pcfg_pkg::pcfg_p3_pad_t  p3_pad;
  } pcfg_state_t;

  pcfg_state_t s_q;
  pcfg_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic       pg_main;
  logic       pg_alt;
  logic       sel_p2_skip;
  logic       sel_p2_analog;
  logic       sel_p2_mode;
  logic       sel_p2_drive;
  logic       sel_p3_latch;
  logic       sel_p3_analog;
  logic       sel_p3_mode;
  logic       sel_p3_drive;
  logic       sel_any;
  logic [7:0] p3_digital_rd;

  assign pg_main       = i_sfr_req.page == pcfg_pkg::PG_MAIN;
  assign pg_alt        = i_sfr_req.page == pcfg_pkg::PG_ALT;
  assign sel_p2_skip   = pg_main
                       & (i_sfr_req.addr == pcfg_pkg::AD_P2_CROSSBAR_SKIP);
  assign sel_p2_analog = pg_main
                       & (i_sfr_req.addr == pcfg_pkg::AD_P2_ANALOG_SELECT);
  assign sel_p2_mode   = pg_main
                       & (i_sfr_req.addr == pcfg_pkg::AD_P2_MODE_OR_DRIVE);
  assign sel_p2_drive  = pg_alt
                       & (i_sfr_req.addr == pcfg_pkg::AD_P2_MODE_OR_DRIVE);
  // port 3 data has no page qualifier
  assign sel_p3_latch  = i_sfr_req.addr == pcfg_pkg::AD_P3_LATCH_DATA;
  assign sel_p3_analog = pg_alt
                       & (i_sfr_req.addr == pcfg_pkg::AD_P3_ANALOG_SELECT);
  assign sel_p3_mode   = pg_alt
                       & (i_sfr_req.addr == pcfg_pkg::AD_P3_OUTPUT_MODE);
  assign sel_p3_drive  = pg_alt
                       & (i_sfr_req.addr == pcfg_pkg::AD_P3_DRIVE_STRENGTH);
  assign sel_any = sel_p2_skip | sel_p2_analog | sel_p2_mode | sel_p2_drive
                 | sel_p3_latch | sel_p3_analog | sel_p3_mode | sel_p3_drive;

  ////////////////////////////////////////////////////////////////////////////
  // per-pin pad logic
  logic [7:0] p3_oe_n_d;
  logic [7:0] p2_rx_d;

  for (genvar n = 0; n < 8; n++) begin : g_pin
    // driver active for a low latch or push-pull; analog ignored
    assign p3_oe_n_d[n] = ~(s_q.p3_mode[n] | ~s_q.p3_latch[n]);
    // receiver gated off in analog mode
    assign p3_digital_rd[n] = i_p3_pin[n] & s_q.p3_analog[n];
    if (n == pcfg_pkg::P2_ANALOG_RSVD_BIT) begin : g_rsvd
      assign p2_rx_d[n] = pcfg_pkg::P2_ANALOG_RSVD_VAL;
    end else begin : g_cfg
      assign p2_rx_d[n] = s_q.p2_analog[n];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    if (i_sfr_req.wr) begin
      if (sel_p2_skip) begin
        s_d.p2_skip = i_sfr_req.wdata;
      end
      if (sel_p2_analog) begin
        s_d.p2_analog = i_sfr_req.wdata[6:0];
      end
      if (sel_p2_mode) begin
        s_d.p2_mode = i_sfr_req.wdata;
      end
      if (sel_p2_drive) begin
        s_d.p2_drive = i_sfr_req.wdata;
      end
      if (sel_p3_latch) begin
        s_d.p3_latch = i_sfr_req.wdata;
      end
      if (sel_p3_analog) begin
        s_d.p3_analog = i_sfr_req.wdata;
      end
      if (sel_p3_mode) begin
        s_d.p3_mode = i_sfr_req.wdata;
      end
      if (sel_p3_drive) begin
        s_d.p3_drive = i_sfr_req.wdata;
      end
    end else if (i_sfr_req.bit_wr && sel_p3_latch) begin
      s_d.p3_latch[i_sfr_req.bit_idx] = i_sfr_req.bit_val;
    end

    // read answer, one cycle after the strobe
    s_d.rsp.hit   = i_sfr_req.rd & sel_any;
    s_d.rsp.rdata = 8'h00;
    if (i_sfr_req.rd) begin
      unique case (1'b1)
        sel_p2_skip:   s_d.rsp.rdata = s_q.p2_skip;
        sel_p2_analog: s_d.rsp.rdata = {pcfg_pkg::P2_ANALOG_RSVD_VAL,
                                        s_q.p2_analog};
        sel_p2_mode:   s_d.rsp.rdata = s_q.p2_mode;
        sel_p2_drive:  s_d.rsp.rdata = s_q.p2_drive;
        sel_p3_latch:  s_d.rsp.rdata = p3_digital_rd;
        sel_p3_analog: s_d.rsp.rdata = s_q.p3_analog;
        sel_p3_mode:   s_d.rsp.rdata = s_q.p3_mode;
        sel_p3_drive:  s_d.rsp.rdata = s_q.p3_drive;
        default:       s_d.rsp.rdata = 8'h00;
      endcase
    end

    // port 2 pad configuration
    s_d.p2_cfg.skip       = s_q.p2_skip;
    s_d.p2_cfg.rx_en      = p2_rx_d;
    s_d.p2_cfg.push_pull  = s_q.p2_mode;
    s_d.p2_cfg.high_drive = s_q.p2_drive;

    // port 3 pad drive
    s_d.p3_pad.out        = s_q.p3_latch;
    s_d.p3_pad.oe_n       = p3_oe_n_d;
    s_d.p3_pad.high_drive = s_q.p3_drive;
    s_d.p3_pad.rx_en      = s_q.p3_analog;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s_q.p2_skip          <= pcfg_pkg::RV_P2_CROSSBAR_SKIP;
      s_q.p2_analog        <= pcfg_pkg::RV_P2_ANALOG_SELECT;
      s_q.p2_mode          <= pcfg_pkg::RV_P2_OUTPUT_MODE;
      s_q.p2_drive         <= pcfg_pkg::RV_P2_DRIVE_STRENGTH;
      s_q.p3_latch         <= pcfg_pkg::RV_P3_LATCH_DATA;
      s_q.p3_analog        <= pcfg_pkg::RV_P3_ANALOG_SELECT;
      s_q.p3_mode          <= pcfg_pkg::RV_P3_OUTPUT_MODE;
      s_q.p3_drive         <= pcfg_pkg::RV_P3_DRIVE_STRENGTH;
      s_q.rsp              <= '0;
      s_q.p2_cfg.skip      <= pcfg_pkg::RV_P2_CROSSBAR_SKIP;
      s_q.p2_cfg.rx_en     <= {pcfg_pkg::P2_ANALOG_RSVD_VAL,
                               pcfg_pkg::RV_P2_ANALOG_SELECT};
      s_q.p2_cfg.push_pull <= pcfg_pkg::RV_P2_OUTPUT_MODE;
      s_q.p2_cfg.high_drive <= pcfg_pkg::RV_P2_DRIVE_STRENGTH;
      s_q.p3_pad.out       <= pcfg_pkg::RV_P3_LATCH_DATA;
      // latch high and open-drain: all pins released
      s_q.p3_pad.oe_n      <= 8'hff;
      s_q.p3_pad.high_drive <= pcfg_pkg::RV_P3_DRIVE_STRENGTH;
      s_q.p3_pad.rx_en     <= pcfg_pkg::RV_P3_ANALOG_SELECT;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sfr_rsp = s_q.rsp;
  assign o_p2_cfg  = s_q.p2_cfg;
  assign o_p3_pad  = s_q.p3_pad;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_P3_READ_PINS:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.rd && i_sfr_req.addr == pcfg_pkg::AD_P3_LATCH_DATA
      |=> o_sfr_rsp.hit
          && o_sfr_rsp.rdata == ($past(i_p3_pin) & $past(s_q.p3_analog)))
    else $error("port 3 read did not return sensed pins");

  AST_P2_RSVD_READS_ONE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.rd && i_sfr_req.page == pcfg_pkg::PG_MAIN
      && i_sfr_req.addr == pcfg_pkg::AD_P2_ANALOG_SELECT
      |=> o_sfr_rsp.rdata[7] == 1'b1)
    else $error("port 2 analog reserved bit read as zero");

  AST_P3_LATCH_ANY_PAGE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.addr == pcfg_pkg::AD_P3_LATCH_DATA
      |=> s_q.p3_latch == $past(i_sfr_req.wdata)
          ##1 o_p3_pad.out == $past(i_sfr_req.wdata, 2))
    else $error("port 3 latch write lost");

  AST_P3_BIT_WRITE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_sfr_req.wr && i_sfr_req.bit_wr
      && i_sfr_req.addr == pcfg_pkg::AD_P3_LATCH_DATA
      |=> s_q.p3_latch[$past(i_sfr_req.bit_idx)] == $past(i_sfr_req.bit_val))
    else $error("port 3 bit write not applied");

  AST_A6_PAGE_SPLIT:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_ALT
      && i_sfr_req.addr == pcfg_pkg::AD_P2_MODE_OR_DRIVE
      |=> s_q.p2_drive == $past(i_sfr_req.wdata) && $stable(s_q.p2_mode))
    else $error("0xa6 on the alternate page hit the wrong register");

  AST_P3_CFG_PAGE_ONLY:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page != pcfg_pkg::PG_ALT
      |=> $stable(s_q.p3_analog) && $stable(s_q.p3_mode)
          && $stable(s_q.p3_drive))
    else $error("port 3 config written off its page");

  AST_P2_SKIP_TO_PAD:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_MAIN
      && i_sfr_req.addr == pcfg_pkg::AD_P2_CROSSBAR_SKIP
      |=> ##1 o_p2_cfg.skip == $past(i_sfr_req.wdata, 2))
    else $error("skip bits did not reach the crossbar");

  AST_OPEN_DRAIN_RELEASE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_p3_pad.oe_n == $past(~s_q.p3_mode & s_q.p3_latch))
    else $error("port 3 driver enable wrong for its mode");

  AST_RX_FOLLOWS_ANALOG:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_p3_pad.rx_en == $past(s_q.p3_analog)
          && o_p2_cfg.rx_en[6:0] == $past(s_q.p2_analog))
    else $error("receiver enable does not follow analog select");

  AST_DRIVE_STRENGTH:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_p3_pad.high_drive == $past(s_q.p3_drive)
          && o_p2_cfg.high_drive == $past(s_q.p2_drive))
    else $error("drive strength outputs stale");

  AST_UNMAPPED_READ:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.rd && !sel_any
      |=> !o_sfr_rsp.hit && o_sfr_rsp.rdata == 8'h00)
    else $error("unmapped read answered");

  AST_P2_ANALOG_WRITE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_MAIN
      && i_sfr_req.addr == pcfg_pkg::AD_P2_ANALOG_SELECT
      |=> s_q.p2_analog == $past(i_sfr_req.wdata[6:0]))
    else $error("port 2 analog select write lost");

  AST_A6_MAIN_PAGE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_MAIN
      && i_sfr_req.addr == pcfg_pkg::AD_P2_MODE_OR_DRIVE
      |=> s_q.p2_mode == $past(i_sfr_req.wdata) && $stable(s_q.p2_drive))
    else $error("0xa6 on the main page hit the wrong register");

  AST_P3_ANALOG_WRITE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_ALT
      && i_sfr_req.addr == pcfg_pkg::AD_P3_ANALOG_SELECT
      |=> s_q.p3_analog == $past(i_sfr_req.wdata))
    else $error("port 3 analog select write lost");

  AST_P3_MODE_WRITE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_ALT
      && i_sfr_req.addr == pcfg_pkg::AD_P3_OUTPUT_MODE
      |=> s_q.p3_mode == $past(i_sfr_req.wdata))
    else $error("port 3 output mode write lost");

  AST_P3_DRIVE_WRITE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page == pcfg_pkg::PG_ALT
      && i_sfr_req.addr == pcfg_pkg::AD_P3_DRIVE_STRENGTH
      |=> s_q.p3_drive == $past(i_sfr_req.wdata))
    else $error("port 3 drive strength write lost");

  AST_P2_RX_RSVD_HIGH:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      o_p2_cfg.rx_en[7] == 1'b1)
    else $error("port 2 pin 7 receiver enable dropped");

  AST_P3_OUT_FOLLOWS_LATCH:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_p3_pad.out == $past(s_q.p3_latch))
    else $error("port 3 pad level does not follow latch");

  AST_P2_MODE_TO_PAD:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_p2_cfg.push_pull == $past(s_q.p2_mode))
    else $error("port 2 driver type does not follow mode");

  AST_BYTE_OVER_BIT:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.bit_wr
      && i_sfr_req.addr == pcfg_pkg::AD_P3_LATCH_DATA
      |=> s_q.p3_latch == $past(i_sfr_req.wdata))
    else $error("bit write overrode a byte write");

  AST_READ_IDLE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_sfr_req.rd
      |=> !o_sfr_rsp.hit && o_sfr_rsp.rdata == 8'h00)
    else $error("read answer without a read strobe");

  AST_P2_CFG_PAGE_ONLY:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      i_sfr_req.wr && i_sfr_req.page != pcfg_pkg::PG_MAIN
      |=> $stable(s_q.p2_skip) && $stable(s_q.p2_analog))
    else $error("port 2 config written off its page");

  AST_P3_LATCH_IDLE:
    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_sfr_req.wr && !i_sfr_req.bit_wr
      |=> $stable(s_q.p3_latch))
    else $error("port 3 latch changed without a write");

endmodule : pcfg_port_config

/* File: sim/pcfg_pin_model.sv */
// pcfg_pin_model: port 3 pads with pull-ups and outside drivers
`timescale 1ns/1ps

module pcfg_pin_model (
  // clock
  input  wire logic                   i_ref_clk,
  // pad controls and outside drivers
  input  wire pcfg_pkg::pcfg_p3_pad_t i_pad,
  input  wire logic [7:0]             i_ext_en,
  input  wire logic [7:0]             i_ext_lvl,
  // sensed levels
  output logic [7:0]                  o_pin
);
  logic [7:0] float_q = 8'h55;

  // floating analog pins wander every cycle
  always_ff @(posedge i_ref_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (!i_pad.oe_n[n]) begin
        o_pin[n] = i_pad.out[n];
      end else if (i_ext_en[n]) begin
        o_pin[n] = i_ext_lvl[n];
      end else if (i_pad.rx_en[n]) begin
        o_pin[n] = 1'b1;
      end else begin
        o_pin[n] = float_q[n];
      end
    end
  end
endmodule : pcfg_pin_model

/* File: sim/tb.sv */
// tb: register map, pad and readback tests for the port block
`timescale 1ns/1ps

module tb;
  //////////////////////////////////////////////////////////////////////////
  localparam int NR = 8;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  pcfg_pkg::pcfg_sfr_req_t req = '0;
  pcfg_pkg::pcfg_sfr_rsp_t rsp;
  pcfg_pkg::pcfg_p2_cfg_t  p2;
  pcfg_pkg::pcfg_p3_pad_t  p3;
  logic [7:0]              pin;
  logic [7:0]              ext_en = 8'h00;
  logic [7:0]              ext_lvl = 8'h00;
  logic [7:0]              rdv;
  logic                    rhit;
  logic [7:0]              lat;
  int                      errors = 0;
  int                      samples_checked = 0;
  // b0 tried on an odd page, it answers everywhere
  logic [7:0] tpg [NR] = '{8'h0f, 8'h00, 8'h0f, 8'h37,
                           8'h0f, 8'h00, 8'h0f, 8'h00};
  logic [7:0] tad [NR] = '{8'ha1, 8'ha6, 8'ha6, 8'hb0,
                           8'hb1, 8'hd6, 8'hf1, 8'hf3};
  logic [7:0] trv [NR] = '{8'h00, 8'h00, 8'h00, 8'hff,
                           8'h00, 8'h00, 8'hff, 8'hff};
  // reserved port 2 analog bit always written as 1
  logic [7:0] twv [NR] = '{8'h3c, 8'ha5, 8'h5a, 8'h96,
                           8'h0f, 8'hc3, 8'hf0, 8'h80};
  logic [7:0] tev [NR] = '{8'h3c, 8'ha5, 8'h5a, 8'h96,
                           8'h0f, 8'hc3, 8'hf0, 8'h80};

  always #20 clk = ~clk;

  pcfg_port_config DUT (
    .i_ref_clk (clk),
    .i_rst_n   (rst_n),
    .i_sfr_req (req),
    .o_sfr_rsp (rsp),
    .i_p3_pin  (pin),
    .o_p2_cfg  (p2),
    .o_p3_pad  (p3)
  );

  pcfg_pin_model u_pins (
    .i_ref_clk (clk),
    .i_pad     (p3),
    .i_ext_en  (ext_en),
    .i_ext_lvl (ext_lvl),
    .o_pin     (pin)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic put(input pcfg_pkg::pcfg_sfr_req_t r);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= '0;
  endtask : put

  task automatic wr(input logic [7:0] pg, input logic [7:0] ad,
                    input logic [7:0] d);
    put('{page:pg, addr:ad, wr:1'b1, wdata:d, default:'0});
  endtask : wr

  task automatic bw(input logic [7:0] pg, input logic [7:0] ad,
                    input logic [2:0] i, input logic v);
    put('{page:pg, addr:ad, bit_wr:1'b1, bit_idx:i, bit_val:v,
          default:'0});
  endtask : bw

  task automatic rchk(input logic [7:0] pg, input logic [7:0] ad,
                      input logic [7:0] exp, input logic h);
    put('{page:pg, addr:ad, rd:1'b1, default:'0});
    #1;
    rdv = rsp.rdata;
    rhit = rsp.hit;
    check(rdv, exp, $sformatf("read %h:%h", pg, ad));
    check(rhit, h, $sformatf("hit %h:%h", pg, ad));
  endtask : rchk

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // driven pins show latch, released ones outside level or pull-up
  function automatic logic [7:0] sense(input logic [7:0] lt,
      input logic [7:0] md, input logic [7:0] an, input logic [7:0] en,
      input logic [7:0] lv);
    logic [7:0] rel;
    rel = ~md & lt;
    return ((~rel & lt) | (rel & en & lv) | (rel & ~en & an)) & an;
  endfunction : sense

  task automatic chk_reset();
    // released pulled-up pins make the b0 read equal its latch reset
    for (int i = 0; i < NR; i++) begin
      rchk(tpg[i], tad[i], trv[i], 1'b1);
    end
    check(p2, {8'h00, 8'hff, 8'h00, 8'h00}, "p2 reset");
    check(p3, {8'hff, 8'hff, 8'h00, 8'hff}, "p3 reset");
  endtask : chk_reset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #(3000 * 40);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk_reset();
    $display("test reset values done");
    for (int i = 0; i < NR; i++) begin
      wr(tpg[i], tad[i], twv[i]);
    end
    settle();
    check(p2, {8'hc3, 8'h80, 8'ha5, 8'h5a}, "p2 pads");
    check(p3, {8'h96, ~8'h0f & 8'h96, 8'h3c, 8'hf0}, "p3");
    for (int i = 0; i < NR; i++) begin
      rchk(tpg[i], tad[i], (i == 3) ? sense(8'h96, 8'h0f, 8'hf0, 8'h00,
           8'h00) : tev[i], 1'b1);
    end
    $display("test map write read done");
    wr(8'h0f, 8'hd6, 8'hff);
    wr(8'h00, 8'hf1, 8'h00);
    rchk(8'h00, 8'hd6, 8'hc3, 1'b1);
    rchk(8'h0f, 8'hf1, 8'hf0, 1'b1);
    rchk(8'h00, 8'ha1, 8'h00, 1'b0);
    rchk(8'h01, 8'hd6, 8'h00, 1'b0);
    $display("test wrong page done");
    @(posedge clk);
    ext_en <= 8'h10;
    ext_lvl <= 8'h00;
    rchk(8'h00, 8'hb0, sense(8'h96, 8'h0f, 8'hf0, 8'h10, 8'h00),
         1'b1);
    $display("test pin readback done");
    lat = 8'h96;
    for (int i = 0; i < 8; i++) begin
      lat[i] = ~lat[i];
      bw(8'h0f, 8'hb0, 3'(i), lat[i]);
      @(posedge clk);
      #1;
      check(p3.out, lat, "bit write");
    end
    put('{page:8'h00, addr:8'hb0, wr:1'b1, bit_wr:1'b1, bit_val:1'b1,
          default:'0});
    bw(8'h0f, 8'ha1, 3'h0, 1'b1);
    settle();
    check(p3.out, 8'h00, "byte over bit");
    check(p3.oe_n, 8'h00, "latch low drives");
    check(p3.high_drive, 8'h3c, "bit write elsewhere");
    $display("test bit write done");
    @(posedge clk);
    rst_n <= 1'b0;
    ext_en <= 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_reset();
    $display("test second reset done");
    report_and_stop();
  end
endmodule : tb
